// *** rtl/ssl_cfg.svh ***
// Constants for the serial setting loader
`ifndef SSL_CFG_SVH
`define SSL_CFG_SVH
`define SSL_WORD_W 16
`define SSL_DEV_ADDR 4'hA
`define SSL_DEV_LSB 0
`define SSL_SUB_LSB 4
`define SSL_SUB_KICK 2'h0
`define SSL_SUB_HOME 2'h1
`define SSL_SUB_POWER 2'h3
`define SSL_FIELD_LSB 8
`define SSL_CODE6_LSB 10
`define SSL_OUT_VAL_BIT 6
`define SSL_OUT_EN_BIT 7
`define SSL_SET_RST 10'h000
`define SSL_LIM_OFF 2'h3
`define SSL_LIM_LOW 2'h0
`define SSL_LIM_MID 2'h1
`define SSL_LIM_HIGH 2'h2
`endif

// *** rtl/ssl_pkg.sv ***
// Types for the serial setting loader
package ssl_pkg;
  typedef enum logic [2:0] {
    SSL_IDLE = 3'b001,
    SSL_SHIFT = 3'b010,
    SSL_LOAD = 3'b100
  } ssl_state_e;
  typedef enum logic [3:0] {
    SSL_CLAMP_LOW = 4'b0001,
    SSL_CLAMP_MID = 4'b0010,
    SSL_CLAMP_HIGH = 4'b0100,
    SSL_CLAMP_OFF = 4'b1000
  } ssl_limit_e;
endpackage

// *** rtl/ssl_sync.sv ***
// Two-stage synchroniser with edge detection on the second stage
`timescale 1ns/1ps
module ssl_sync #(
  // Level held by every stage in reset; set it to the pin's idle level
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin in, synchronised level out
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Only sync_q reads meta_q; edges come from the later stages
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      prev_q <= RST_VAL;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Level and edges
  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule

// *** rtl/ssl_loader.sv ***
// Three-wire serial setting loader with three setting latches
`timescale 1ns/1ps
`include "ssl_cfg.svh"
module ssl_loader (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial programming pins
  input wire logic ser_data,
  input wire logic ser_clk,
  input wire logic ser_strobe,
  // Power-down level, has no effect on the loader
  input wire logic power_down,
  // Analog settings
  output logic [5:0] kick_code,
  output logic [3:0] limit_select,
  output logic [5:0] home_code,
  output logic [1:0] home_offset_code,
  output logic [7:0] power_level_code,
  // General output pin
  output logic aux_out_pin_o,
  output logic aux_out_pin_oe,
  // Load event, one cycle per accepted word
  output logic load_pulse
);
  localparam int WORD_W = `SSL_WORD_W;

  logic data_s;
  logic clk_rise;
  logic strobe_s;
  logic strobe_rise;
  logic strobe_fall;
  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] shift_d;
  logic [9:0] kick_set_q;
  logic [9:0] home_set_q;
  logic [9:0] power_set_q;
  ssl_pkg::ssl_state_e state_q;
  ssl_pkg::ssl_state_e state_d;
  logic [3:0] limit_q;
  logic [5:0] kick_q;
  logic [5:0] home_q;
  logic [1:0] offset_q;
  logic [7:0] power_q;
  logic pin_q;
  logic pin_oe_q;
  logic load_q;
  logic pd_s;

  // Latch select decode, used only by the load; the checks decode the word on their own
  function automatic logic [2:0] sel_decode(input logic [WORD_W-1:0] w);
    logic hit;
    hit = (w[`SSL_DEV_LSB +: 4] == `SSL_DEV_ADDR);
    sel_decode = {hit & (w[`SSL_SUB_LSB +: 2] == `SSL_SUB_POWER),
                  hit & (w[`SSL_SUB_LSB +: 2] == `SSL_SUB_HOME),
                  hit & (w[`SSL_SUB_LSB +: 2] == `SSL_SUB_KICK)};
  endfunction

  // Pins are asynchronous to clk, so each passes two flops first
  ssl_sync u_data_sync (
    .clk(clk), .rst(rst), .pin(ser_data), .level(data_s), .rise(), .fall());
  ssl_sync u_clk_sync (
    .clk(clk), .rst(rst), .pin(ser_clk), .level(), .rise(clk_rise), .fall());
  // Strobe idles high, so its stages reset high and no false rise follows reset
  ssl_sync #(.RST_VAL(1'b1)) u_strobe_sync (
    .clk(clk), .rst(rst), .pin(ser_strobe), .level(strobe_s), .rise(strobe_rise),
    .fall(strobe_fall));
  // Power-down is only watched by the checks, the loader never looks at it
  ssl_sync u_pd_sync (
    .clk(clk), .rst(rst), .pin(power_down), .level(pd_s), .rise(), .fall());

  // Data is delayed as much as the clock, so the sampled bit matches its edge
  wire shift_en = (state_q == ssl_pkg::SSL_SHIFT) & clk_rise & ~strobe_s;
  wire [2:0] load_sel = (state_q == ssl_pkg::SSL_SHIFT) & strobe_rise ?
                        sel_decode(shift_q) : 3'h0;
  wire [9:0] data_field = shift_q[WORD_W-1:6];

  // Newest bit enters at the bottom so the first bit ends at the top
  assign shift_d = shift_en ? {shift_q[WORD_W-2:0], data_s} : shift_q;

  // Framing state: idle until strobe falls, shift, load on strobe rise
  always_comb begin
    state_d = state_q;
    case (state_q)
      ssl_pkg::SSL_IDLE: begin
        if (strobe_fall) begin
          state_d = ssl_pkg::SSL_SHIFT;
        end
      end
      ssl_pkg::SSL_SHIFT: begin
        if (strobe_rise) begin
          state_d = ssl_pkg::SSL_LOAD;
        end
      end
      ssl_pkg::SSL_LOAD: begin
        state_d = ssl_pkg::SSL_IDLE;
      end
      default: begin
        state_d = ssl_pkg::SSL_IDLE;
      end
    endcase
  end

  // A frame opens only on a strobe fall seen from idle
  frame_open_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ssl_pkg::SSL_IDLE) && strobe_fall |=> state_q == ssl_pkg::SSL_SHIFT)
    else $error("frame did not open on strobe fall");

  // A frame closes on the strobe rise and always passes through the load state
  frame_close_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ssl_pkg::SSL_SHIFT) && strobe_rise |=> state_q == ssl_pkg::SSL_LOAD)
    else $error("frame did not close on strobe rise");

  // Load lasts one cycle; the host's strobe-high time covers it
  load_state_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ssl_pkg::SSL_LOAD) |=> state_q == ssl_pkg::SSL_IDLE)
    else $error("load state held too long");

  // State and shift register; power_down is deliberately not looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ssl_pkg::SSL_IDLE;
      shift_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
    end
  end

  // Shifting happens only inside a frame; stray clocks leave the word alone
  shift_gated_a: assert property (@(posedge clk) disable iff (rst)
    strobe_s |=> shift_q == $past(shift_q))
    else $error("shift register moved while strobe high");

  outside_frame_a: assert property (@(posedge clk) disable iff (rst)
    (state_q != ssl_pkg::SSL_SHIFT) |=> $stable(shift_q))
    else $error("shift register moved outside a frame");

  // Each clock rise inside a frame moves the word up one place; the oldest bit falls out of the top
  shift_order_a: assert property (@(posedge clk) disable iff (rst)
    shift_en |=> shift_q[0] == $past(data_s) && shift_q[15:1] == $past(shift_q[14:0]))
    else $error("shift order wrong");

  // Power-down must not stall the loader; the host may program it then
  pd_shift_a: assert property (@(posedge clk) disable iff (rst)
    pd_s && shift_en |=> shift_q[0] == $past(data_s))
    else $error("no shift during power-down");

  // Setting latches, one per used subaddress
  always_ff @(posedge clk) begin
    if (rst) begin
      kick_set_q <= `SSL_SET_RST;
      home_set_q <= `SSL_SET_RST;
      power_set_q <= `SSL_SET_RST;
    end else begin
      if (load_sel[0]) begin
        kick_set_q <= data_field;
      end
      if (load_sel[1]) begin
        home_set_q <= data_field;
      end
      if (load_sel[2]) begin
        power_set_q <= data_field;
      end
    end
  end

  // At most one latch per word; foreign words and the spare subaddress load nothing
  load_one_a: assert property (@(posedge clk) disable iff (rst)
    $onehot0(load_sel))
    else $error("more than one latch loaded");

  foreign_word_a: assert property (@(posedge clk) disable iff (rst)
    (shift_q[3:0] != `SSL_DEV_ADDR) |-> load_sel == 3'h0)
    else $error("load for foreign address");

  spare_sub_a: assert property (@(posedge clk) disable iff (rst)
    (shift_q[5:4] == 2'h2) |-> load_sel == 3'h0)
    else $error("load for unused subaddress");

  // Loads happen only at a frame end, and the low six bits pick the latch
  frame_only_a: assert property (@(posedge clk) disable iff (rst)
    (state_q != ssl_pkg::SSL_SHIFT) || !strobe_rise |-> load_sel == 3'h0)
    else $error("load outside a frame end");

  kick_pick_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ssl_pkg::SSL_SHIFT) && strobe_rise && (shift_q[5:0] == 6'h0A)
      |-> load_sel == 3'h1)
    else $error("kick word not taken at strobe rise");

  home_pick_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ssl_pkg::SSL_SHIFT) && strobe_rise && (shift_q[5:0] == 6'h1A)
      |-> load_sel == 3'h2)
    else $error("home word not taken at strobe rise");

  power_pick_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ssl_pkg::SSL_SHIFT) && strobe_rise && (shift_q[5:0] == 6'h3A)
      |-> load_sel == 3'h4)
    else $error("power word not taken at strobe rise");

  // Power-down leaves the latches writable
  pd_load_a: assert property (@(posedge clk) disable iff (rst)
    pd_s && load_sel[2] |=> power_set_q == $past(shift_q[15:6]))
    else $error("power latch not loaded during power-down");

  // Limiter select decode to a one-hot analog select
  wire [1:0] lim_code = kick_set_q[3:2];
  wire [3:0] lim_sel = (lim_code == `SSL_LIM_OFF) ? ssl_pkg::SSL_CLAMP_OFF :
                       (lim_code == `SSL_LIM_LOW) ? ssl_pkg::SSL_CLAMP_LOW :
                       (lim_code == `SSL_LIM_MID) ? ssl_pkg::SSL_CLAMP_MID :
                       ssl_pkg::SSL_CLAMP_HIGH;

  // Outputs registered so every port comes from a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      limit_q <= ssl_pkg::SSL_CLAMP_LOW;
      kick_q <= 6'h00;
      home_q <= 6'h00;
      offset_q <= 2'h0;
      power_q <= 8'h00;
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      limit_q <= lim_sel;
      kick_q <= kick_set_q[9:4];
      home_q <= home_set_q[9:4];
      offset_q <= home_set_q[3:2];
      power_q <= power_set_q[9:2];
      pin_q <= power_set_q[0];
      pin_oe_q <= power_set_q[1];
      load_q <= |load_sel;
    end
  end

  assign limit_select = limit_q;
  assign kick_code = kick_q;
  assign home_code = home_q;
  assign home_offset_code = offset_q;
  assign power_level_code = power_q;
  assign aux_out_pin_o = pin_q;
  assign aux_out_pin_oe = pin_oe_q;
  assign load_pulse = load_q;

  // Output fields settle two cycles after the load decision
  kick_load_a: assert property (@(posedge clk) disable iff (rst)
    load_sel[0] |=> kick_set_q == $past(data_field) ##1 kick_code == $past(data_field[9:4], 2))
    else $error("kick latch not loaded");

  power_load_a: assert property (@(posedge clk) disable iff (rst)
    load_sel[2] |-> ##2 power_level_code == $past(shift_q[15:8], 2))
    else $error("power field misplaced");

  pin_drive_a: assert property (@(posedge clk) disable iff (rst)
    load_sel[2] |-> ##2 aux_out_pin_oe == $past(shift_q[7], 2)
      && aux_out_pin_o == $past(shift_q[6], 2))
    else $error("output pin bits wrong");

  // Limiter code 11 must switch the analog limiter off
  limit_off_a: assert property (@(posedge clk) disable iff (rst)
    (kick_set_q[3:2] == 2'h3) |=> limit_select == 4'h8)
    else $error("limiter off not selected");

  offset_map_a: assert property (@(posedge clk) disable iff (rst)
    load_sel[1] |-> ##2 home_offset_code == $past(shift_q[9:8], 2))
    else $error("home offset misplaced");

  // Latches hold between loads, whatever the power-down level
  stable_idle_a: assert property (@(posedge clk) disable iff (rst)
    (load_sel == 3'h0)
      |=> $stable(power_set_q) && $stable(home_set_q) && $stable(kick_set_q))
    else $error("latch changed without load");

  // Home and limiter fields, held against the word layout
  home_load_a: assert property (@(posedge clk) disable iff (rst)
    load_sel[1] |-> ##2 home_code == $past(shift_q[15:10], 2))
    else $error("home code misplaced");

  limit_map_a: assert property (@(posedge clk) disable iff (rst)
    load_sel[0] |-> ##2 limit_select == (4'h1 << $past(shift_q[9:8], 2)))
    else $error("limiter select misplaced");

  // One pulse per accepted word, never stretched
  pulse_follow_a: assert property (@(posedge clk) disable iff (rst)
    (load_sel != 3'h0) |=> load_pulse)
    else $error("no load pulse after a load");

  pulse_once_a: assert property (@(posedge clk) disable iff (rst)
    load_pulse |=> !load_pulse)
    else $error("load pulse longer than one cycle");
endmodule

// *** testbench/ssl_host.sv ***
// Host model driving the three-wire serial programming bus
`timescale 1ns/1ps
module ssl_host (
  // Clock
  input wire logic clk,
  // Serial programming pins
  output logic ser_data,
  output logic ser_clk,
  output logic ser_strobe
);
  // Bus idles with strobe high and serial clock standing low
  initial begin
    ser_data = 1'b0;
    ser_clk = 1'b0;
    ser_strobe = 1'b1;
  end
  // Wait a number of system clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One serial clock pulse, 200 ns period, data set well before the rise
  task automatic pulse(input logic b);
    ser_data <= b;
    tick(4);
    ser_clk <= 1'b1;
    tick(4);
    ser_clk <= 1'b0;
  endtask
  // Stray clocks with strobe high, then the low n bits of w in one frame
  task automatic send(input logic [31:0] w, input int n);
    int i;
    for (i = 0; i < 3; i++) pulse(~w[i]);
    tick(4);
    ser_strobe <= 1'b0;
    tick(4);
    for (i = n - 1; i >= 0; i--) pulse(w[i]);
    tick(4);
    ser_strobe <= 1'b1;
    ser_data <= ~ser_data; // Released line must not show a stale bit
    tick(12);
  endtask
endmodule

// *** testbench/ssl_loader_test.sv ***
// Self-checking bench for the serial setting loader
`timescale 1ns/1ps
`include "ssl_cfg.svh"
module ssl_loader_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic power_down = 1'b0;
  wire ser_data, ser_clk, ser_strobe;
  logic [5:0] kick_code, home_code;
  logic [3:0] limit_select;
  logic [1:0] home_offset_code;
  logic [7:0] power_level_code;
  logic aux_out_pin_o, aux_out_pin_oe, load_pulse;
  int num_errors = 0;
  int tests_run = 0;
  int pulses = 0;
  int exp_pulses = 0;
  int m_kick = 0, m_lim = 0, m_home = 0, m_off = 0, m_pl = 0, m_out = 0, m_en = 0;
  logic [31:0] seed = 32'h0000CD01;
  // 40 MHz system clock
  always #12.5 clk = ~clk;
  ssl_loader i_ssl_loader (.clk(clk), .rst(rst), .ser_data(ser_data), .ser_clk(ser_clk),
    .ser_strobe(ser_strobe), .power_down(power_down), .kick_code(kick_code),
    .limit_select(limit_select), .home_code(home_code), .home_offset_code(home_offset_code),
    .power_level_code(power_level_code), .aux_out_pin_o(aux_out_pin_o),
    .aux_out_pin_oe(aux_out_pin_oe), .load_pulse(load_pulse));
  ssl_host i_ssl_host (.clk(clk), .ser_data(ser_data), .ser_clk(ser_clk),
    .ser_strobe(ser_strobe));
  // Count load events as the design reports them
  always @(posedge clk) begin
    if (load_pulse === 1'b1) pulses++;
  end
  // Step of the random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // One comparison, four-state
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
      num_errors++;
    end
  endtask
  // All outputs against the model
  task automatic check_all();
    chk("kick_code", m_kick, kick_code);
    chk("limit_select", 16'h1 << m_lim, limit_select);
    chk("home_code", m_home, home_code);
    chk("home_offset_code", m_off, home_offset_code);
    chk("power_level_code", m_pl, power_level_code);
    chk("aux_out_pin_o", m_out, aux_out_pin_o);
    chk("aux_out_pin_oe", m_en, aux_out_pin_oe);
    chk("load count", exp_pulses, pulses);
  endtask
  // Verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog, about three times the expected run
  initial begin
    #600000;
    num_errors++;
    print_verdict();
  end
  // Reset, then random words; first twelve walk every two-bit code per subaddress
  initial begin
    int i;
    int sub;
    int n;
    int k;
    bit bits_q[$];
    logic [15:0] word;
    logic [31:0] w;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    check_all();
    $display("test reset done");
    for (i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      sub = (i < 12) ? ((i / 4 == 2) ? 3 : i / 4) : int'(seed[4:3]);
      w = seed;
      w[5:4] = sub[1:0];
      if (i >= 12 && seed[6:5] == 2'h0) w[3:0] = seed[10:7];
      else w[3:0] = `SSL_DEV_ADDR;
      // Spare bits differ from the field bits so a misplaced field shows
      if (i < 12) w[9:6] = {i[1:0], ~i[1:0]};
      power_down <= seed[11];
      n = 16 + seed[13:12] + seed[14];
      // Model register: every bit sent in order, only the newest sixteen survive
      bits_q.delete();
      for (k = n - 1; k >= 0; k--) bits_q.push_back(w[k]);
      while (bits_q.size() > 16) void'(bits_q.pop_front());
      word = 16'h0000;
      foreach (bits_q[j]) word = {word[14:0], bits_q[j]};
      if (word[3:0] == `SSL_DEV_ADDR && word[5:4] != 2'h2) begin
        exp_pulses++;
        if (word[5:4] == `SSL_SUB_KICK) begin
          m_kick = word[15:10];
          m_lim = word[9:8];
        end else if (word[5:4] == `SSL_SUB_HOME) begin
          m_home = word[15:10];
          m_off = word[9:8];
        end else begin
          m_pl = word[15:8];
          m_en = word[7];
          m_out = word[6];
        end
      end
      i_ssl_host.send(w, n);
      check_all();
    end
    $display("test words done");
    // Reset in mid-run must clear every latch back to its reset value
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    m_kick = 0;
    m_lim = 0;
    m_home = 0;
    m_off = 0;
    m_pl = 0;
    m_out = 0;
    m_en = 0;
    repeat (8) @(posedge clk);
    check_all();
    $display("test mid reset done");
    print_verdict();
  end
endmodule
